// *** include/lor_pkg.sv ***
package lor_pkg;
    // Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
    localparam logic [9:0]  IDX_AUX_CTRL      = 10'h1ba;
    localparam logic [9:0]  IDX_CHAN_CTRL     = 10'h1bb;
    localparam logic [9:0]  IDX_LOCK_RB       = 10'h22c;
    localparam logic [9:0]  IDX_HOLD_RB       = 10'h22d;
    localparam logic [9:0]  IDX_IRQ_STATUS    = 10'h240;
    localparam logic [9:0]  IDX_IRQ_MASK      = 10'h241;
    localparam int          ADDR_W            = 12;

    localparam int          AUX_SEL_HI        = 7;
    localparam int          AUX_SEL_LO        = 5;
    localparam int          AUX_WEAK_BIT      = 4;
    localparam int          AUX_DIV_HI        = 3;
    localparam int          CHAN_PD_BIT       = 7;
    localparam int          CHAN_SEL_HI       = 6;
    localparam int          CHAN_SEL_LO       = 4;
    localparam int          CHAN_VCXO_HI      = 3;

    localparam logic [7:0]  AUX_CTRL_RESET    = 8'h01;
    localparam logic [7:0]  CHAN_CTRL_RESET   = 8'h00;
    localparam logic [3:0]  DIV_BY1           = 4'h0;
    localparam logic [3:0]  DIV_BY2           = 4'h1;
    localparam logic [3:0]  DIV_BY4           = 4'h2;
    localparam logic [3:0]  DIV_BY8           = 4'h4;
    localparam logic [3:0]  DIV_BY16          = 4'h8;

    // Interrupt events: 0 holdover entered, 1 first-loop lock lost,
    // 2 second-loop lock lost, 3 calibration done, 4 illegal divider code written
    localparam int          IRQ_W             = 5;
    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;

    typedef enum logic [1:0] {
        LOR_VCO_DIV_ONE,
        LOR_VCO_DIV_TWO
    } lor_src_t;

    function automatic logic lor_div_legal(input logic [3:0] code);
        return (code == DIV_BY1) || (code == DIV_BY2) || (code == DIV_BY4) ||
               (code == DIV_BY8) || (code == DIV_BY16);
    endfunction : lor_div_legal
endpackage : lor_pkg

// *** include/lor_status_if.sv ***
interface lor_status_if;
    logic [7:0] lockRaw;
    logic [7:0] holdRaw;
    logic [7:0] lockSync;
    logic [7:0] holdSync;
    modport capture (input lockRaw, input holdRaw, output lockSync, output holdSync);
    modport user    (output lockRaw, output holdRaw, input lockSync, input holdSync);
endinterface : lor_status_if

// *** logic/lor_status_capture.sv ***
module lor_status_capture
    import lor_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst_n,
    lor_status_if.capture    st
);
    logic [7:0] lockReg;
    logic [7:0] lockNext;
    logic [7:0] holdReg;
    logic [7:0] holdNext;

    // Registered snapshot so a read sees a stable byte
    always_comb begin
        lockNext = st.lockRaw;
        holdNext = st.holdRaw;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lockReg <= 8'h00;
            holdReg <= 8'h00;
        end else begin
            lockReg <= lockNext;
            holdReg <= holdNext;
        end
    end

    assign st.lockSync = lockReg;
    assign st.holdSync = holdReg;
endmodule : lor_status_capture

// *** logic/lor_regs.sv ***
// Notes on behaviour
// - Aux control bits 7,6,5 pick divider one (0) or two (1) for channels 6,5,4.
// - Channel control bits 6,5,4 pick divider one (0) or two (1) for channels 9,8,7.
// - Aux control bit 4 set gives weak CMOS drive on the aux output, clear gives strong.
// - Aux control bits 3:0 are a divider code, 0000 (divide by 1) or one-hot, 0001 (divide by 2) after reset.
// - Channel control bit 7 powers down the aux output driver.
// - Channel control bits 3:0 route the VCXO clock (1) or VCO divider clock (0) to channels 3:0.
// - Lock readback bits 7:2 show presence of each monitored clock.
// - Holdover readback bit 3 is high while holdover is active.
// - Holdover readback bit 2 shows the automatically chosen reference, 1 secondary.
// - Holdover readback bit 0 is high while a VCO calibration runs.
//
// Decided for this implementation: the AXI4-Lite slave port.
module lor_regs
    import lor_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              secondaryRefPresent,
    input  wire logic              primaryRefPresent,
    input  wire logic              secondLoopRefPresent,
    input  wire logic              secondLoopFbPresent,
    input  wire logic              vcxoPresent,
    input  wire logic              testRefPresent,
    input  wire logic              firstLoopLocked,
    input  wire logic              secondLoopLocked,
    input  wire logic              autoRefSecondary,
    input  wire logic              vcoCalBusy,
    output logic [5:0]             vcoDividerChannelChoice,
    output logic                   firstLoopAuxOutputWeak,
    output logic [3:0]             firstLoopAuxOutputDivider,
    output logic                   firstLoopAuxOutputPowerDown,
    output logic [3:0]             vcxoToChannel,
    output logic                   irq
);
    lor_status_if st ();

    logic [7:0]        auxReg;
    logic [7:0]        auxNext;
    logic [7:0]        chanReg;
    logic [7:0]        chanNext;
    logic [IRQ_W-1:0]  irqStatReg;
    logic [IRQ_W-1:0]  irqStatNext;
    logic [IRQ_W-1:0]  irqMaskReg;
    logic [IRQ_W-1:0]  irqMaskNext;
    logic [7:0]        lockPrevReg;
    logic [7:0]        lockPrevNext;
    logic [7:0]        holdPrevReg;
    logic [7:0]        holdPrevNext;

    logic              awHeldReg;
    logic              awHeldNext;
    logic [ADDR_W-1:0] awAddrReg;
    logic [ADDR_W-1:0] awAddrNext;
    logic              wHeldReg;
    logic              wHeldNext;
    logic [31:0]       wDataReg;
    logic [31:0]       wDataNext;
    logic [3:0]        wStrbReg;
    logic [3:0]        wStrbNext;
    logic              bValidReg;
    logic              bValidNext;
    logic [1:0]        bRespReg;
    logic [1:0]        bRespNext;
    logic              rValidReg;
    logic              rValidNext;
    logic [31:0]       rDataReg;
    logic [31:0]       rDataNext;
    logic [1:0]        rRespReg;
    logic [1:0]        rRespNext;

    logic              doWrite;
    logic [9:0]        wIdx;
    logic [IRQ_W-1:0]  events;

    lor_status_capture u_capture (
        .clk   (clk),
        .rst_n (rst_n),
        .st    (st)
    );

    assign st.lockRaw = {secondLoopRefPresent, secondLoopFbPresent, vcxoPresent,
                         testRefPresent, secondaryRefPresent, primaryRefPresent,
                         secondLoopLocked, firstLoopLocked};
    assign st.holdRaw = {4'h0, ~(primaryRefPresent | secondaryRefPresent),
                         autoRefSecondary, 1'b0, vcoCalBusy};

    function automatic logic [9:0] lor_index(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2];
    endfunction : lor_index

    function automatic logic lor_mapped(input logic [9:0] idx);
        return (idx == IDX_AUX_CTRL) || (idx == IDX_CHAN_CTRL) || (idx == IDX_LOCK_RB) ||
               (idx == IDX_HOLD_RB) || (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK);
    endfunction : lor_mapped

    // Address and data may arrive in either order; one write in flight at a time
    assign s_axi_awready = !awHeldReg && !bValidReg;
    assign s_axi_wready  = !wHeldReg && !bValidReg;
    assign s_axi_arready = !rValidReg;
    assign doWrite       = awHeldReg && wHeldReg && !bValidReg;
    assign wIdx          = lor_index(awAddrReg);

    always_comb begin
        awHeldNext = awHeldReg;
        awAddrNext = awAddrReg;
        wHeldNext  = wHeldReg;
        wDataNext  = wDataReg;
        wStrbNext  = wStrbReg;
        bValidNext = bValidReg;
        bRespNext  = bRespReg;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeldNext = 1'b1;
            awAddrNext = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeldNext = 1'b1;
            wDataNext = s_axi_wdata;
            wStrbNext = s_axi_wstrb;
        end
        if (doWrite) begin
            awHeldNext = 1'b0;
            wHeldNext  = 1'b0;
            bValidNext = 1'b1;
            bRespNext  = lor_mapped(wIdx) ? RESP_OKAY : RESP_SLVERR;
        end else if (bValidReg && s_axi_bready) begin
            bValidNext = 1'b0;
        end
    end

    // Events 3:0 come from edges of the registered status snapshot, event 4 from an illegal divider code write
    always_comb begin
        events       = '0;
        events[0]    = st.holdSync[3] & ~holdPrevReg[3];
        events[1]    = ~st.lockSync[0] & lockPrevReg[0];
        events[2]    = ~st.lockSync[1] & lockPrevReg[1];
        events[3]    = ~st.holdSync[0] & holdPrevReg[0];
        lockPrevNext = st.lockSync;
        holdPrevNext = st.holdSync;
        auxNext      = auxReg;
        chanNext     = chanReg;
        irqMaskNext  = irqMaskReg;
        irqStatNext  = irqStatReg;
        if (doWrite && wStrbReg[0]) begin
            unique case (wIdx)
                IDX_AUX_CTRL: begin
                    // Illegal divider code keeps the old divider; guards the output
                    auxNext[AUX_SEL_HI:AUX_WEAK_BIT] = wDataReg[AUX_SEL_HI:AUX_WEAK_BIT];
                    if (lor_div_legal(wDataReg[AUX_DIV_HI:0])) begin
                        auxNext[AUX_DIV_HI:0] = wDataReg[AUX_DIV_HI:0];
                    end else begin
                        events[4] = 1'b1;
                    end
                end
                IDX_CHAN_CTRL:  chanNext    = wDataReg[7:0];
                IDX_IRQ_STATUS: irqStatNext = irqStatReg & ~wDataReg[IRQ_W-1:0];
                IDX_IRQ_MASK:   irqMaskNext = wDataReg[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
        // Set wins over a same-cycle clear
        irqStatNext = irqStatNext | events;
    end

    always_comb begin
        rValidNext = rValidReg;
        rDataNext  = rDataReg;
        rRespNext  = rRespReg;
        if (s_axi_arvalid && s_axi_arready) begin
            rValidNext = 1'b1;
            rRespNext  = RESP_OKAY;
            unique case (lor_index(s_axi_araddr))
                IDX_AUX_CTRL:   rDataNext = {24'h000000, auxReg};
                IDX_CHAN_CTRL:  rDataNext = {24'h000000, chanReg};
                IDX_LOCK_RB:    rDataNext = {24'h000000, st.lockSync};
                IDX_HOLD_RB:    rDataNext = {24'h000000, st.holdSync};
                IDX_IRQ_STATUS: rDataNext = {27'h0000000, irqStatReg};
                IDX_IRQ_MASK:   rDataNext = {27'h0000000, irqMaskReg};
                default: begin
                    rDataNext = 32'h00000000;
                    rRespNext = RESP_SLVERR;
                end
            endcase
        end else if (rValidReg && s_axi_rready) begin
            rValidNext = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            auxReg      <= AUX_CTRL_RESET;
            chanReg     <= CHAN_CTRL_RESET;
            irqStatReg  <= '0;
            irqMaskReg  <= '0;
            lockPrevReg <= 8'h00;
            holdPrevReg <= 8'h00;
            awHeldReg   <= 1'b0;
            awAddrReg   <= '0;
            wHeldReg    <= 1'b0;
            wDataReg    <= 32'h00000000;
            wStrbReg    <= 4'h0;
            bValidReg   <= 1'b0;
            bRespReg    <= RESP_OKAY;
            rValidReg   <= 1'b0;
            rDataReg    <= 32'h00000000;
            rRespReg    <= RESP_OKAY;
        end else begin
            auxReg      <= auxNext;
            chanReg     <= chanNext;
            irqStatReg  <= irqStatNext;
            irqMaskReg  <= irqMaskNext;
            lockPrevReg <= lockPrevNext;
            holdPrevReg <= holdPrevNext;
            awHeldReg   <= awHeldNext;
            awAddrReg   <= awAddrNext;
            wHeldReg    <= wHeldNext;
            wDataReg    <= wDataNext;
            wStrbReg    <= wStrbNext;
            bValidReg   <= bValidNext;
            bRespReg    <= bRespNext;
            rValidReg   <= rValidNext;
            rDataReg    <= rDataNext;
            rRespReg    <= rRespNext;
        end
    end

    assign s_axi_bvalid = bValidReg;
    assign s_axi_bresp  = bRespReg;
    assign s_axi_rvalid = rValidReg;
    assign s_axi_rdata  = rDataReg;
    assign s_axi_rresp  = rRespReg;

    // Channel order 9..4 high to low, 1 means divider two
    assign vcoDividerChannelChoice     = {chanReg[CHAN_SEL_HI:CHAN_SEL_LO],
                                          auxReg[AUX_SEL_HI:AUX_SEL_LO]};
    assign firstLoopAuxOutputWeak      = auxReg[AUX_WEAK_BIT];
    assign firstLoopAuxOutputDivider   = auxReg[AUX_DIV_HI:0];
    assign firstLoopAuxOutputPowerDown = chanReg[CHAN_PD_BIT];
    assign vcxoToChannel               = chanReg[CHAN_VCXO_HI:0];
    assign irq                         = |(irqStatReg & irqMaskReg);
endmodule : lor_regs

// *** tb/lor_regs_properties.sv ***
module lor_regs_properties
    import lor_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [5:0]  vcoDividerChannelChoice,
    input wire logic        firstLoopAuxOutputWeak,
    input wire logic [3:0]  firstLoopAuxOutputDivider,
    input wire logic        firstLoopAuxOutputPowerDown,
    input wire logic [3:0]  vcxoToChannel,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence writeAnswer;
        $rose(s_axi_bvalid);
    endsequence
    sequence readTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    reset_values_a: assert property (!$past(rst_n) |-> firstLoopAuxOutputDivider == 4'h1
        && !firstLoopAuxOutputPowerDown && vcxoToChannel == 4'h0 && !irq)
        else $error("config outputs wrong after reset");
    div_legal_a: assert property (lor_div_legal(firstLoopAuxOutputDivider))
        else $error("aux divider holds an illegal code");
    cfg_change_a: assert property (!$stable({vcoDividerChannelChoice, firstLoopAuxOutputWeak,
        firstLoopAuxOutputDivider, firstLoopAuxOutputPowerDown, vcxoToChannel}) |-> writeAnswer)
        else $error("config output changed without a write");
    read_answer_a: assert property (readTaken |=> s_axi_rvalid)
        else $error("read answer late");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
endmodule : lor_regs_properties

bind lor_regs lor_regs_properties u_lor_regs_properties (.*);

// *** tb/tb.sv ***
module tb;
    import lor_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = '0;
    logic [11:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [5:0]  vcoDividerChannelChoice;
    logic [3:0]  firstLoopAuxOutputDivider, vcxoToChannel;
    logic        firstLoopAuxOutputWeak, firstLoopAuxOutputPowerDown, irq;
    // Status inputs laid out as the lock readback, then auto select and calibration
    logic [9:0]  st = 10'h0ff;
    logic [33:0] rq[$];
    logic [1:0]  wq[$];
    logic [7:0]  v;
    logic [7:0]  chanVal;
    logic [3:0]  codes[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    integer      seed = 32'hd54a51bd;
    int          errCount = 0;
    int          testsRun = 0;

    lor_regs u_lor_regs (.*, .secondaryRefPresent(st[3]), .primaryRefPresent(st[2]),
        .secondLoopRefPresent(st[7]), .secondLoopFbPresent(st[6]), .vcxoPresent(st[5]),
        .testRefPresent(st[4]), .firstLoopLocked(st[0]), .secondLoopLocked(st[1]),
        .autoRefSecondary(st[8]), .vcoCalBusy(st[9]));

    always #20 clk = ~clk;

    function automatic logic [11:0] ba(input logic [9:0] i);
        return {i, 2'b00};
    endfunction : ba

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic endOfTest;
        if (errCount == 0 && testsRun > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : endOfTest

    // Ready raised once both valids have dropped, on the same edge as the write answer, so it is taken at once
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        wq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            // Only one assignment to bready per step, the exit drops it
            if (!(s_axi_bvalid && s_axi_bready)) s_axi_bready <= !s_axi_awvalid && !s_axi_wvalid;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [11:0] a, input logic [33:0] e);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (!(s_axi_rvalid && s_axi_rready)) s_axi_rready <= !s_axi_arvalid;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask : axr

    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, wq.pop_front());
    end

    initial begin
        repeat (4000) @(posedge clk);
        errCount++;
        endOfTest();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        axr(ba(IDX_AUX_CTRL), {RESP_OKAY, 32'h01});
        axr(ba(IDX_CHAN_CTRL), {RESP_OKAY, 32'h00});
        foreach (codes[i]) begin
            v = 8'($random(seed));
            axw(ba(IDX_AUX_CTRL), {24'h0, v[7:4], codes[i]}, RESP_OKAY);
            axr(ba(IDX_AUX_CTRL), {RESP_OKAY, 24'h0, v[7:4], codes[i]});
            check(firstLoopAuxOutputDivider, codes[i]);
            check(firstLoopAuxOutputWeak, v[4]);
            check(vcoDividerChannelChoice[2:0], v[7:5]);
        end
        repeat (4) begin
            chanVal = 8'($random(seed));
            axw(ba(IDX_CHAN_CTRL), {24'h0, chanVal}, RESP_OKAY);
            check(firstLoopAuxOutputPowerDown, chanVal[7]);
            check(vcoDividerChannelChoice[5:3], chanVal[6:4]);
            check(vcxoToChannel, chanVal[3:0]);
        end
        // Illegal divider code: upper field lands, divider keeps divide by 16
        axw(ba(IDX_AUX_CTRL), 32'hb3, RESP_OKAY);
        axr(ba(IDX_AUX_CTRL), {RESP_OKAY, 32'hb8});
        check(irq, 1'b0);
        axr(ba(IDX_IRQ_STATUS), {RESP_OKAY, 32'h10});
        axw(ba(IDX_IRQ_MASK), 32'h1f, RESP_OKAY);
        check(irq, 1'b1);
        axw(ba(IDX_IRQ_STATUS), 32'h10, RESP_OKAY);
        check(irq, 1'b0);
        repeat (6) begin
            st <= 10'($random(seed));
            repeat (2) @(posedge clk);
            axr(ba(IDX_LOCK_RB), {RESP_OKAY, 24'h0, st[7:0]});
            axr(ba(IDX_HOLD_RB), {RESP_OKAY, 28'h0, !(st[3] | st[2]), st[8], 1'b0, st[9]});
        end
        // Known start, clear, then lose locks and references while calibration ends
        st <= 10'h2ff;
        repeat (3) @(posedge clk);
        axw(ba(IDX_IRQ_STATUS), 32'h1f, RESP_OKAY);
        st <= 10'h0f0;
        repeat (3) @(posedge clk);
        axr(ba(IDX_IRQ_STATUS), {RESP_OKAY, 32'h0f});
        check(irq, 1'b1);
        axw(ba(IDX_LOCK_RB), 32'hff, RESP_OKAY);
        axr(ba(IDX_LOCK_RB), {RESP_OKAY, 24'h0, st[7:0]});
        axr(12'h800, {RESP_SLVERR, 32'h0});
        axw(12'h800, 32'h1, RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        axw(ba(IDX_CHAN_CTRL), {24'h0, ~chanVal}, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axr(ba(IDX_CHAN_CTRL), {RESP_OKAY, 24'h0, chanVal});
        endOfTest();
    end
endmodule : tb
